// [pkg/oms_pkg.sv]
package oms_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [6:0] SETUP_ADDR      = 7'h00;
    localparam logic [6:0] LINE_STATE_ADDR = 7'h07;
    localparam logic [6:0] BAUD_ADDR       = 7'h01;
    localparam logic [6:0] SCAN_CTRL_ADDR  = 7'h02;
    localparam logic [6:0] DWELL_LO_ADDR   = 7'h03;
    localparam logic [6:0] DWELL_HI_ADDR   = 7'h04;
    // Setup fields
    localparam int TX_FORCE_BIT   = 0;
    // Line state fields
    localparam int KEYED_BIT      = 0;
    localparam int DIR_BIT        = 1;
    localparam int CD_BIT         = 2;
    localparam int PORT_LSB       = 4;
    // Scan control fields
    localparam int SCAN_STEP_BIT  = 0;
    localparam int SCAN_AUTO_BIT  = 1;
    localparam int SCAN_MODE_LSB  = 2;
    // SPI frame
    localparam int FRAME_BITS     = 16;
    localparam int READ_FLAG_BIT  = 15;
    // Timing
    localparam int DIR_DWELL_BITS = 16;
    localparam int SCAN_PRESET16  = 16;
    localparam logic [11:0] CUSTOM_DWELL_RST = 12'h051;
    localparam int NUM_PORTS      = 4;
    localparam real REF_CLK_MHZ   = 8.704;
    localparam real SYS_CLK_MHZ   = 250.0;
    localparam int REF_HALF_CYC   = int'(SYS_CLK_MHZ / (REF_CLK_MHZ * 2.0));
    // Baud select: reference ticks per bit period
    localparam logic [15:0] TICKS_9600   = 16'h0389;
    localparam logic [15:0] TICKS_38400  = 16'h00E2;
    localparam logic [15:0] TICKS_115200 = 16'h004B;
    localparam logic [1:0]  BAUD_RST     = 2'h0;

    typedef enum logic [1:0] {
        SCAN_ONE,
        SCAN_SIXTEEN,
        SCAN_CUSTOM
    } oms_scan_t;
endpackage

// [src/oms_core.sv]
`timescale 1ns/1ps
module oms_core #(
    parameter int NPORT = oms_pkg::NUM_PORTS
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       transmit_key_input_n,
    input  wire logic       carrier_in,
    input  wire logic       spi_sclk,
    input  wire logic       spi_cs_n,
    input  wire logic       spi_mosi,
    output logic            spi_miso,
    output logic            tx_carrier_en,
    output logic            direction_out,
    output logic            carrier_detect_output,
    output logic [NPORT-1:0] port_sel
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0]  setup_r;
    logic [1:0]  baud_r;
    logic [7:0]  scan_ctrl_r;
    logic [11:0] custom_dwell_r;
    logic [1:0]  port_r;
    logic        dir_r;
    logic        carrier_d_r;
    logic        sclk_d_r;
    logic [4:0]  bit_cnt_r;
    logic [15:0] shift_r;
    logic [7:0]  rd_data_r;
    logic        step_req;
    logic [7:0]  line_state;
    logic        keyed;

    assign keyed = setup_r[oms_pkg::TX_FORCE_BIT] | ~transmit_key_input_n;
    assign line_state = {2'h0, port_r, 1'b0, ~carrier_in, dir_r, keyed};

    // ----------------------------------------------------------------
    // SPI slave, 16-bit frames, mode 0
    // ----------------------------------------------------------------
    logic sclk_rise;
    logic sclk_fall;
    logic frame_done;
    assign sclk_rise  = spi_sclk & ~sclk_d_r & ~spi_cs_n;
    assign sclk_fall  = ~spi_sclk & sclk_d_r & ~spi_cs_n;
    assign frame_done = sclk_rise && bit_cnt_r == 5'(oms_pkg::FRAME_BITS - 1);

    function automatic logic [7:0] reg_read(input logic [6:0] a);
        reg_read = 8'h00;
        case (a)
            oms_pkg::SETUP_ADDR:      reg_read = setup_r;
            oms_pkg::BAUD_ADDR:       reg_read = {6'h00, baud_r};
            oms_pkg::SCAN_CTRL_ADDR:  reg_read = scan_ctrl_r;
            oms_pkg::DWELL_LO_ADDR:   reg_read = custom_dwell_r[7:0];
            oms_pkg::DWELL_HI_ADDR:   reg_read = {4'h0, custom_dwell_r[11:8]};
            oms_pkg::LINE_STATE_ADDR: reg_read = line_state;
            default:                  reg_read = 8'h00;
        endcase
    endfunction

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d_r  <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r   <= 16'h0000;
            rd_data_r <= 8'h00;
            spi_miso  <= 1'b0;
        end else begin
            sclk_d_r <= spi_sclk;
            if (spi_cs_n) begin
                bit_cnt_r <= 5'h00;
                spi_miso  <= 1'b0;
            end else begin
                if (sclk_rise) begin
                    shift_r   <= {shift_r[14:0], spi_mosi};
                    bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
                    if (bit_cnt_r == 5'h07) begin
                        rd_data_r <= reg_read({shift_r[5:0], spi_mosi});
                    end
                end
                if (sclk_fall && bit_cnt_r >= 5'h08) begin
                    spi_miso  <= rd_data_r[7];
                    rd_data_r <= {rd_data_r[6:0], 1'b0};
                end
            end
        end
    end

    logic       wr_now;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    assign wr_now  = frame_done && !shift_r[oms_pkg::READ_FLAG_BIT - 1];
    assign wr_addr = shift_r[13:7];
    assign wr_data = {shift_r[6:0], spi_mosi};
    assign step_req = wr_now && wr_addr == oms_pkg::SCAN_CTRL_ADDR && wr_data[oms_pkg::SCAN_STEP_BIT];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            setup_r        <= 8'h00;
            baud_r         <= oms_pkg::BAUD_RST;
            scan_ctrl_r    <= 8'h00;
            custom_dwell_r <= oms_pkg::CUSTOM_DWELL_RST;
        end else if (wr_now) begin
            case (wr_addr)
                oms_pkg::SETUP_ADDR:     setup_r <= wr_data;
                oms_pkg::BAUD_ADDR:      baud_r <= wr_data[1:0];
                oms_pkg::SCAN_CTRL_ADDR: scan_ctrl_r <= {wr_data[7:1], 1'b0};
                oms_pkg::DWELL_LO_ADDR:  custom_dwell_r[7:0] <= wr_data;
                oms_pkg::DWELL_HI_ADDR:  custom_dwell_r[11:8] <= wr_data[3:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Reference tick and bit period
    // ----------------------------------------------------------------
    logic [7:0]  ref_cnt_r;
    logic [15:0] bit_tick_cnt_r;
    logic        bit_tick_r;
    logic [15:0] ticks_per_bit;
    always_comb begin
        case (baud_r)
            2'h1:    ticks_per_bit = oms_pkg::TICKS_38400;
            2'h2:    ticks_per_bit = oms_pkg::TICKS_115200;
            default: ticks_per_bit = oms_pkg::TICKS_9600;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ref_cnt_r      <= 8'h00;
            bit_tick_cnt_r <= 16'h0000;
            bit_tick_r     <= 1'b0;
        end else begin
            bit_tick_r <= 1'b0;
            if (ref_cnt_r == 8'(2 * oms_pkg::REF_HALF_CYC - 1)) begin
                ref_cnt_r <= 8'h00;
                if (bit_tick_cnt_r >= ticks_per_bit - 16'h0001) begin
                    bit_tick_cnt_r <= 16'h0000;
                    bit_tick_r     <= 1'b1;
                end else begin
                    bit_tick_cnt_r <= bit_tick_cnt_r + 16'h0001;
                end
            end else begin
                ref_cnt_r <= ref_cnt_r + 8'h01;
            end
        end
    end

    // ----------------------------------------------------------------
    // Direction dwell
    // ----------------------------------------------------------------
    logic [4:0] dir_cnt_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carrier_d_r <= 1'b0;
            dir_r       <= 1'b0;
            dir_cnt_r   <= 5'h00;
        end else begin
            carrier_d_r <= carrier_in;
            if (carrier_in || carrier_in != carrier_d_r) begin
                dir_r     <= 1'b1;
                dir_cnt_r <= 5'h00;
            end else if (dir_r && bit_tick_r) begin
                if (dir_cnt_r == 5'(oms_pkg::DIR_DWELL_BITS - 1)) begin
                    dir_r     <= 1'b0;
                    dir_cnt_r <= 5'h00;
                end else begin
                    dir_cnt_r <= dir_cnt_r + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            direction_out         <= 1'b0;
            carrier_detect_output <= 1'b1;
            tx_carrier_en         <= 1'b0;
        end else begin
            direction_out         <= dir_r;
            carrier_detect_output <= ~carrier_in;
            tx_carrier_en         <= keyed;
        end
    end

    // ----------------------------------------------------------------
    // Port scanner
    // ----------------------------------------------------------------
    logic [11:0] scan_cnt_r;
    logic [11:0] scan_limit;
    logic        scan_auto;
    oms_pkg::oms_scan_t scan_mode;
    assign scan_auto = scan_ctrl_r[oms_pkg::SCAN_AUTO_BIT];
    assign scan_mode = oms_pkg::oms_scan_t'(scan_ctrl_r[oms_pkg::SCAN_MODE_LSB +: 2]);
    always_comb begin
        case (scan_mode)
            oms_pkg::SCAN_ONE:     scan_limit = 12'h000;
            oms_pkg::SCAN_SIXTEEN: scan_limit = 12'(oms_pkg::SCAN_PRESET16 - 1);
            oms_pkg::SCAN_CUSTOM:  scan_limit = custom_dwell_r - 12'h001; // 0 means 4096
            default:               scan_limit = 12'h000;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            port_r     <= 2'h0;
            scan_cnt_r <= 12'h000;
        end else if (!scan_auto) begin
            scan_cnt_r <= 12'h000;
            if (step_req) begin
                port_r <= port_r + 2'h1;
            end
        end else if (bit_tick_r) begin
            if (scan_cnt_r >= scan_limit) begin
                scan_cnt_r <= 12'h000;
                port_r     <= port_r + 2'h1;
            end else begin
                scan_cnt_r <= scan_cnt_r + 12'h001;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    port_sel[g] <= (g == 0);
                end else begin
                    port_sel[g] <= (32'(port_r) == g);
                end
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_tx_keyed: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> tx_carrier_en == $past(keyed)) else $error("carrier enable wrong");
    a_dir_rise: assert property (@(posedge clk) disable iff (rst)
        carrier_in |=> dir_r ##1 direction_out) else $error("direction not raised");
    a_dir_hold: assert property (@(posedge clk) disable iff (rst)
        dir_r && !bit_tick_r && !carrier_in |=> dir_r) else $error("direction dropped early");
    a_cd_pin: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> carrier_detect_output == !$past(carrier_in)) else $error("carrier detect wrong");
    a_dir_drop: assert property (@(posedge clk) disable iff (rst)
        dir_r && bit_tick_r && !carrier_in && carrier_d_r == carrier_in && dir_cnt_r == 5'(oms_pkg::DIR_DWELL_BITS - 1)
        |=> !dir_r) else $error("dwell expiry missed");
    a_restart: assert property (@(posedge clk) disable iff (rst)
        carrier_in != carrier_d_r |=> dir_cnt_r == 5'h00) else $error("dwell not restarted");
    a_manual_step: assert property (@(posedge clk) disable iff (rst)
        !scan_auto && step_req |=> port_r == $past(port_r) + 2'h1) else $error("manual step lost");
    a_auto_hold: assert property (@(posedge clk) disable iff (rst)
        scan_auto && !bit_tick_r |=> $stable(port_r)) else $error("port moved off tick");
    a_one_hot: assert property (@(posedge clk) disable iff (rst)
        $onehot(port_sel)) else $error("port select not one-hot");
    a_dir_pin: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> direction_out == $past(dir_r)) else $error("direction pin wrong");
    a_dir_idle: assert property (@(posedge clk) disable iff (rst)
        !dir_r && !carrier_in && carrier_in == carrier_d_r |=> !dir_r)
        else $error("direction rose without carrier");
    a_tick_align: assert property (@(posedge clk) disable iff (rst)
        bit_tick_r |-> ref_cnt_r == 8'h00 && bit_tick_cnt_r == 16'h0000)
        else $error("bit tick off period boundary");
    a_scan_wrap: assert property (@(posedge clk) disable iff (rst)
        scan_auto && bit_tick_r && scan_cnt_r >= scan_limit |=> port_r == $past(port_r) + 2'h1)
        else $error("scan did not advance");
    a_scan_count: assert property (@(posedge clk) disable iff (rst)
        scan_auto && bit_tick_r && scan_cnt_r < scan_limit |=> scan_cnt_r == $past(scan_cnt_r) + 12'h001)
        else $error("scan dwell count wrong");
    a_manual_hold: assert property (@(posedge clk) disable iff (rst)
        !scan_auto && !step_req |=> $stable(port_r)) else $error("manual port moved");
    a_setup_write: assert property (@(posedge clk) disable iff (rst)
        wr_now && wr_addr == oms_pkg::SETUP_ADDR |=> setup_r == $past(wr_data))
        else $error("setup write lost");
    a_dwell_hold: assert property (@(posedge clk) disable iff (rst)
        carrier_in |=> dir_cnt_r == 5'h00) else $error("dwell ran during carrier");
endmodule

// [verification/oms_host_model.sv]
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Host SPI master, mode 0, sclk just under 8 MHz
// ----------------------------------------------------------------
module oms_host_model (
    input  wire logic clk,
    output logic      spi_sclk,
    output logic      spi_cs_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    initial begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    task automatic half();
        repeat (16) @(negedge clk);
    endtask
    // Sixteen-bit frame, address byte first, MSB first
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = w[i];
            half();
            spi_sclk = 1'b1;
            if (i < 8) begin
                rd[i] = spi_miso;
            end
            half();
            spi_sclk = 1'b0;
        end
        half();
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;
        half();
    endtask
endmodule

// [verification/ook_modem_direction_and_scan_tb_top.sv]
`timescale 1ns/1ps
module ook_modem_direction_and_scan_tb_top;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       key_n = 1'b1;
    logic       carrier = 1'b0;
    logic       sclk;
    logic       cs_n;
    logic       mosi;
    logic       miso;
    logic       tx_en;
    logic       dir;
    logic       cd;
    logic [3:0] port;
    logic [7:0] rd;
    int         fail_count = 0;
    int         total_checks = 0;
    int         cycles = 0;
    int         t_bit = 0;

    oms_core dut_u (.clk(clk), .rst(rst), .transmit_key_input_n(key_n), .carrier_in(carrier),
        .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso), .tx_carrier_en(tx_en),
        .direction_out(dir), .carrier_detect_output(cd), .port_sel(port));
    oms_host_model host_u (.clk(clk), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));

    always #2 clk = ~clk;
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic wrap_up();
        if (fail_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            fail_count++;
            wrap_up();
        end
    end
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic near(input string nm, input int m, input int e, input int tol);
        check(nm, 16'((m > e - tol) && (m < e + tol)), 16'h1);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host_u.xfer({1'b0, a, d}, rd);
    endtask
    task automatic rdr(input logic [6:0] a);
        host_u.xfer({1'b1, a, 8'h00}, rd);
    endtask
    task automatic wait_port(output int n);
        logic [3:0] p;
        p = port;
        n = 0;
        while (port === p && n < 40000) begin
            @(negedge clk);
            n++;
        end
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        check("dir", dir, 16'h0);
        check("cd", cd, 16'h1);
        check("port", port, 16'h1);
        check("tx", tx_en, 16'h0);
        rdr(oms_pkg::DWELL_LO_ADDR);
        check("dwell_lo", rd, 16'h51);
        rdr(oms_pkg::DWELL_HI_ADDR);
        check("dwell_hi", rd, 16'h0);
        rdr(7'h10);
        check("unmapped", rd, 16'h0);
    endtask
    task automatic t_key();
        rdr(oms_pkg::LINE_STATE_ADDR);
        check("dir_bit", rd[oms_pkg::DIR_BIT], 16'h0);
        for (int i = 0; i < 4; i++) begin
            wr(oms_pkg::SETUP_ADDR, {7'h0, i[0]});
            key_n = ~i[1];
            repeat (2) @(negedge clk);
            check("tx", tx_en, 16'(i[0] | i[1]));
            rdr(oms_pkg::LINE_STATE_ADDR);
            check("keyed", rd[oms_pkg::KEYED_BIT], 16'(i[0] | i[1]));
            check("dir_ready", rd[oms_pkg::DIR_BIT], 16'h0);
        end
        wr(oms_pkg::SETUP_ADDR, 8'h00);
        key_n = 1'b1;
    endtask
    task automatic t_manual();
        for (int i = 1; i <= 4; i++) begin
            wr(oms_pkg::SCAN_CTRL_ADDR, 8'h01);
            check("port", port, 16'(4'h1 << (i % 4)));
            rdr(oms_pkg::LINE_STATE_ADDR);
            check("port_idx", rd[oms_pkg::PORT_LSB +: 2], 16'(i % 4));
        end
    endtask
    task automatic t_scan();
        int n;
        int c0;
        int e;
        logic [3:0] p;
        e = int'(oms_pkg::TICKS_115200) * 2 * oms_pkg::REF_HALF_CYC;
        wr(oms_pkg::BAUD_ADDR, 8'h02);
        wr(oms_pkg::DWELL_LO_ADDR, 8'h02);
        wr(oms_pkg::SCAN_CTRL_ADDR, 8'h02);
        wait_port(n);
        for (int i = 0; i < 3; i++) begin
            p = port;
            wait_port(t_bit);
            check("next_port", port, 16'({p[2:0], p[3]}));
        end
        near("bit_period", t_bit, e, e / 50);
        c0 = cycles;
        wr(oms_pkg::SCAN_CTRL_ADDR, 8'h0A);
        wait_port(n);
        near("custom_dwell", cycles - c0, 2 * t_bit, t_bit / 2);
        c0 = cycles;
        wr(oms_pkg::SCAN_CTRL_ADDR, 8'h06);
        wait_port(n);
        near("dwell16", cycles - c0, 16 * t_bit, t_bit);
        wr(oms_pkg::SCAN_CTRL_ADDR, 8'h00);
    endtask
    task automatic t_dir();
        int n;
        carrier = 1'b1;
        n = 0;
        while (dir !== 1'b1 && n < 100) begin
            @(negedge clk);
            n++;
        end
        check("dir", dir, 16'h1);
        check("cd", cd, 16'h0);
        rdr(oms_pkg::LINE_STATE_ADDR);
        check("dir_cd_bits", rd[2:1], 16'h1);
        carrier = 1'b0;
        repeat (t_bit) @(negedge clk);
        check("dir_hold", dir, 16'h1);
        check("cd", cd, 16'h1);
        rdr(oms_pkg::LINE_STATE_ADDR);
        check("cd_bit", rd[oms_pkg::CD_BIT], 16'h1);
        carrier = 1'b1;
        repeat (64) @(negedge clk);
        carrier = 1'b0;
        n = 0;
        while (dir !== 1'b0 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        near("dir_dwell", n, 16 * t_bit, t_bit);
        rdr(oms_pkg::LINE_STATE_ADDR);
        check("dir_bit", rd[oms_pkg::DIR_BIT], 16'h0);
    endtask
    initial begin
        repeat (16) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_reset();
        t_key();
        t_manual();
        t_scan();
        t_dir();
        wrap_up();
    end
endmodule
